// ==== ptimer_pkg.sv ====
// package for the programmable down timer: register map, fields, reset values
// assumes a 32-bit classic wishbone bus, word aligned, byte address offsets
package ptimer_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CNT0_LOW = 8'h00;  // counter 0 low nibble (ro)
  localparam logic [7:0] OFS_CNT0_HIGH = 8'h04; // counter 0 high nibble (ro, latched)
  localparam logic [7:0] OFS_CNT1_LOW = 8'h08;  // counter 1 low nibble (ro)
  localparam logic [7:0] OFS_CNT1_HIGH = 8'h0C; // counter 1 high nibble (ro, latched)
  localparam logic [7:0] OFS_CTRL = 8'h10;      // run, output, chain, clock select
  localparam logic [7:0] OFS_RELOAD0 = 8'h14;   // reload value counter 0
  localparam logic [7:0] OFS_RELOAD1 = 8'h18;   // reload value counter 1
  localparam logic [7:0] OFS_OSC = 8'h1C;       // fast oscillator on
  // control field positions
  localparam int CTL_RUN0 = 0;   // cnt0_run_ctl
  localparam int CTL_RUN1 = 1;   // cnt1_run_ctl
  localparam int CTL_TIMER_OUT_SIGNAL = 2;   // timer_out_enable
  localparam int CTL_CHAIN = 3;  // 16-bit chained mode
  localparam int CTL_EVENT = 4;  // counter 0 clocked from event pin
  localparam int CTL_FAST = 5;   // internal source is fast oscillator
  localparam int CTL_PRE_LO = 8; // unused prescaler select position; ctrl stores bits 5:0 only
  // reset values
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic RST_OSC = 1'b0;
  // internal clock dividers, in sys clocks, per source select (CTL_FAST)
  localparam logic [15:0] DIV_SLOW = 16'h0BEB; // about 32 kHz from 100 MHz
  localparam logic [15:0] DIV_FAST = 16'h0031; // 2 MHz from 100 MHz
endpackage : ptimer_pkg

// ==== ptimer_counter.sv ====
// one 8-bit down counter channel with synchronised run/stop
// assumes a one-cycle falling-edge enable of the channel's input clock
`timescale 1ns/1ps
`default_nettype none
module ptimer_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic fall,
  input wire logic run_req,
  input wire logic [7:0] reload,
  output logic running,
  output logic [7:0] count,
  output logic underflow
);
  // run state follows the request only on an input clock falling edge
  // RL4 synchronised run change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
    end else if (fall) begin
      running <= run_req;
    end
  end

  // decrement, or reload from zero, on every fall while running, including the stopping edge
  // RL5 final decrement on stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 8'h00;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (fall && running) begin
        if (count == 8'h00) begin
          count <= reload;
          underflow <= 1'b1;
        end else begin
          count <= count - 8'h01;
        end
      end
    end
  end

  // stop from a nonzero count takes a decrement at the edge where it is seen
  // RL5 stop one edge late
  property p_stop_decrements;
    @(posedge clk) disable iff (rst)
      (fall && running && !run_req && count != 8'h00) |=> (!running && count == $past(count) - 8'h01);
  endproperty
  a_stop_decrements: assert property (p_stop_decrements) else $error("stop edge missed decrement"); // RL5
  // without a fall the run state holds
  property p_no_edge_no_change;
    @(posedge clk) disable iff (rst)
      !fall |=> $stable(running);
  endproperty
  a_no_edge_no_change: assert property (p_no_edge_no_change) else $error("run changed without edge"); // RL4
endmodule // ptimer_counter
`default_nettype wire

// ==== ptimer_top.sv ====
// top of the programmable down timer with its wishbone register slave
// assumes a single 100 MHz clock; event pin is asynchronous and synchronised here
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: software reads low nibble before high
// RL2: high nibble read soon after low
// RL3: chained mode reads four nibbles in order
// RL4: run change waits for input clock fall
// RL5: stop adds one final decrement
// RL6: run bit reads one until halted
// RL7: event mode needs pin edges to change
// RL8: output enable gates timer output asynchronously
// RL9: software starts fast oscillator before timer
// RL10: reset leaves fast oscillator off
// RL11: software limits serial clock to 1 MHz
// RL12: event pin feeds port and timer
// RL13: low nibble read latches high nibble
module ptimer_top
  import ptimer_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic EVENT_CLOCK_PIN,
  output logic EVENT_PORT_IN,
  output logic TIMER_OUT_SIGNAL,
  output logic FAST_OSCILLATOR_ON
);
  import ptimer_pkg::*;

  logic [31:0] ctrl;          // control register
  logic [7:0] reload0;        // reload value 0
  logic [7:0] reload1;        // reload value 1
  logic osc_on;               // fast oscillator enable
  logic [2:0] pin_sync;       // event pin synchroniser
  logic pin_level;            // agreed pin level
  logic pin_fall;             // agreed falling edge of pin
  logic [15:0] div_cnt;       // internal clock divider
  logic int_fall;             // internal clock falling-edge enable
  logic fall0;                // counter 0 clock enable
  logic fall1;                // counter 1 clock enable
  logic run0;                 // counter 0 running
  logic run1;                 // counter 1 running
  logic [7:0] cnt0;           // counter 0 value
  logic [7:0] cnt1;           // counter 1 value
  logic uf0;                  // counter 0 underflow
  logic uf1;                  // counter 1 underflow
  logic timer_out_signal_raw;             // toggling timer output before gating
  logic [3:0] hold0;          // captured high nibble counter 0
  logic [3:0] hold1;          // captured high nibble counter 1
  logic bus_req;              // new bus request
  logic [31:0] next_rdata;    // read mux value

  // address match helper, used in several decodes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  assign bus_req = CYC_I && STB_I && !ACK_O;

  // three-stage synchroniser on the event pin
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], EVENT_CLOCK_PIN};
    end
  end

  // pin level changes once stages two and three agree
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pin_level <= 1'b0;
      pin_fall <= 1'b0;
    end else begin
      pin_fall <= 1'b0;
      if (pin_sync[1] == pin_sync[2] && pin_sync[2] != pin_level) begin
        pin_level <= pin_sync[2];
        pin_fall <= pin_level;
      end
    end
  end

  // same agreed pin level goes to the general input port
  // RL12 shared pin signal
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      EVENT_PORT_IN <= 1'b0;
    end else begin
      EVENT_PORT_IN <= pin_level;
    end
  end

  // internal clock divider, rate picked by the source select
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_cnt <= 16'h0000;
      int_fall <= 1'b0;
    end else begin
      int_fall <= 1'b0;
      if (ctrl[CTL_FAST] && !osc_on) begin
        // no fast clock while the oscillator is off
        div_cnt <= 16'h0000;
      end else if (div_cnt >= (ctrl[CTL_FAST] ? DIV_FAST : DIV_SLOW)) begin
        div_cnt <= 16'h0000;
        int_fall <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // counter 0 from pin in event mode; counter 1 chained on underflow
  // RL7 event edges drive counter
  assign fall0 = ctrl[CTL_EVENT] ? pin_fall : int_fall;
  assign fall1 = ctrl[CTL_CHAIN] ? uf0 : int_fall;

  ptimer_counter u_cnt0 (
    .clk(SYS_CLK),
    .rst(RST),
    .fall(fall0),
    .run_req(ctrl[CTL_RUN0]),
    .reload(reload0),
    .running(run0),
    .count(cnt0),
    .underflow(uf0)
  );

  ptimer_counter u_cnt1 (
    .clk(SYS_CLK),
    .rst(RST),
    .fall(fall1),
    .run_req(ctrl[CTL_CHAIN] ? ctrl[CTL_RUN0] : ctrl[CTL_RUN1]),
    .reload(reload1),
    .running(run1),
    .count(cnt1),
    .underflow(uf1)
  );

  // control and reload writes on a taken write request
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= RST_CTRL;
      reload0 <= RST_RELOAD;
      reload1 <= RST_RELOAD;
    end else if (bus_req && WE_I && SEL_I[0]) begin
      if (hit(ADR_I, OFS_CTRL)) begin
        ctrl <= {26'h0, DAT_I[5:0]};
      end
      if (hit(ADR_I, OFS_RELOAD0)) begin
        reload0 <= DAT_I[7:0];
      end
      if (hit(ADR_I, OFS_RELOAD1)) begin
        reload1 <= DAT_I[7:0];
      end
    end
  end

  // fast oscillator enable, off after reset
  // RL10 oscillator reset off
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      osc_on <= RST_OSC;
    end else if (bus_req && WE_I && SEL_I[0] && hit(ADR_I, OFS_OSC)) begin
      osc_on <= DAT_I[0];
    end
  end

  // oscillator state to the pin, software waits for it to settle
  // RL9 oscillator state visible
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      FAST_OSCILLATOR_ON <= 1'b0;
    end else begin
      FAST_OSCILLATOR_ON <= osc_on;
    end
  end

  // low nibble read captures the high nibble for a consistent pair
  // RL13 high nibble capture
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hold0 <= 4'h0;
      hold1 <= 4'h0;
    end else if (bus_req && !WE_I) begin
      if (hit(ADR_I, OFS_CNT0_LOW)) begin
        hold0 <= cnt0[7:4];
        // in chained mode the upper byte's high nibble is captured too, for the four-read order
        // RL3 chained snapshot
        if (ctrl[CTL_CHAIN]) begin
          hold1 <= cnt1[7:4];
        end
      end
      if (hit(ADR_I, OFS_CNT1_LOW) && !ctrl[CTL_CHAIN]) begin
        hold1 <= cnt1[7:4];
      end
    end
  end

  // timer output toggles on counter underflow of the last stage
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      timer_out_signal_raw <= 1'b0;
    end else if (ctrl[CTL_CHAIN] ? uf1 : uf0) begin
      timer_out_signal_raw <= ~timer_out_signal_raw;
    end
  end

  // enable gates the output with no alignment to the toggling signal
  // RL8 unsynchronised output gate
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TIMER_OUT_SIGNAL <= 1'b0;
    end else begin
      TIMER_OUT_SIGNAL <= timer_out_signal_raw & ctrl[CTL_TIMER_OUT_SIGNAL];
    end
  end

  // read data mux; run bits show request or, while stopping, still one
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(ADR_I, OFS_CNT0_LOW)) begin
      next_rdata = {28'h0, cnt0[3:0]};
    end else if (hit(ADR_I, OFS_CNT0_HIGH)) begin
      next_rdata = {28'h0, hold0};
    end else if (hit(ADR_I, OFS_CNT1_LOW)) begin
      next_rdata = {28'h0, cnt1[3:0]};
    end else if (hit(ADR_I, OFS_CNT1_HIGH)) begin
      next_rdata = {28'h0, hold1};
    end else if (hit(ADR_I, OFS_CTRL)) begin
      // RL6 run reads one until halted
      next_rdata = {26'h0, ctrl[5:2], ctrl[CTL_RUN1] | run1, ctrl[CTL_RUN0] | run0};
    end else if (hit(ADR_I, OFS_RELOAD0)) begin
      next_rdata = {24'h0, reload0};
    end else if (hit(ADR_I, OFS_RELOAD1)) begin
      next_rdata = {24'h0, reload1};
    end else if (hit(ADR_I, OFS_OSC)) begin
      next_rdata = {31'h0, osc_on};
    end
  end

  // one-wait acknowledge; unmapped reads return zero, writes ignored
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= bus_req;
      if (bus_req && !WE_I) begin
        DAT_O <= next_rdata;
      end
    end
  end

  // the gated output stays low while the enable is off
  property p_timer_out_signal_gated;
    @(posedge SYS_CLK) disable iff (RST)
      (!ctrl[CTL_TIMER_OUT_SIGNAL]) |=> !TIMER_OUT_SIGNAL;
  endproperty
  a_timer_out_signal_gated: assert property (p_timer_out_signal_gated) else $error("output not gated"); // RL8
  // oscillator off right after reset until written
  property p_osc_off;
    @(posedge SYS_CLK) disable iff (RST)
      $rose(osc_on) |-> $past(bus_req && WE_I && hit(ADR_I, OFS_OSC));
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on without write"); // RL10
  // a read run bit of one while still running
  property p_run_reads_one;
    @(posedge SYS_CLK) disable iff (RST)
      (bus_req && !WE_I && hit(ADR_I, OFS_CTRL) && run0) |=> DAT_O[CTL_RUN0];
  endproperty
  a_run_reads_one: assert property (p_run_reads_one) else $error("run read zero while running"); // RL6
  // a low nibble read of counter 0 captures its high nibble into hold0
  property p_capture;
    @(posedge SYS_CLK) disable iff (RST)
      (bus_req && !WE_I && hit(ADR_I, OFS_CNT0_LOW)) |=> (hold0 == $past(cnt0[7:4]));
  endproperty
  a_capture: assert property (p_capture) else $error("high nibble not captured"); // RL13
  // event mode counter 0 moves only on pin edges
  property p_event_only;
    @(posedge SYS_CLK) disable iff (RST)
      (ctrl[CTL_EVENT] && !pin_fall) |=> $stable(cnt0);
  endproperty
  a_event_only: assert property (p_event_only) else $error("counter moved without pin edge"); // RL7
  // port input follows the shared pin level
  property p_pin_shared;
    @(posedge SYS_CLK) disable iff (RST)
      1'b1 |=> (EVENT_PORT_IN == $past(pin_level));
  endproperty
  a_pin_shared: assert property (p_pin_shared) else $error("port and timer differ"); // RL12
  // a timer clock fall shows up as a low level on the port copy
  property p_fall_port;
    @(posedge SYS_CLK) disable iff (RST)
      pin_fall |=> !EVENT_PORT_IN;
  endproperty
  a_fall_port: assert property (p_fall_port) else $error("timer fall not seen on port"); // RL12
  // ack is a single pulse
  property p_ack_pulse;
    @(posedge SYS_CLK) disable iff (RST)
      ACK_O |=> !ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  // oscillator pin mirrors the enable one cycle later
  property p_osc_pin;
    @(posedge SYS_CLK) disable iff (RST)
      1'b1 |=> (FAST_OSCILLATOR_ON == $past(osc_on));
  endproperty
  a_osc_pin: assert property (p_osc_pin) else $error("oscillator pin wrong"); // RL9
endmodule // ptimer_top
`default_nettype wire

// ==== ptimer_event_src.sv ====
// far-side model: drives the event clock pin with one low pulse per request
// assumes the bench raises fire for one cycle while busy is low
`timescale 1ns/1ps
`default_nettype none
module ptimer_event_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  output logic pin,
  output logic busy
);
  logic [4:0] phase; // cycles left in the current pulse

  // pulse on request
  // the pin stands still high unless a pulse is asked for
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 5'h00;
    end else if (fire && phase == 5'h00) begin
      phase <= 5'h18;
    end else if (phase != 5'h00) begin
      phase <= phase - 5'h01;
    end
  end

  // low for the first twelve cycles, then high again
  assign pin = !(phase > 5'h0C);
  assign busy = (phase != 5'h00);
endmodule // ptimer_event_src
`default_nettype wire

// ==== programmable_down_timer_test.sv ====
// bench for the timer: wishbone master, event pin partner, counter model
// assumes ptimer_pkg offsets and a counter that reloads on underflow from 0
`timescale 1ns/1ps
`default_nettype none
module programmable_down_timer_test;
  import ptimer_pkg::*;
  logic SYS_CLK = 1'b0, RST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [7:0] ADR_I = 8'h00;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, DAT_O, rd;
  logic ACK_O, EVENT_CLOCK_PIN, EVENT_PORT_IN, TIMER_OUT_SIGNAL, FAST_OSCILLATOR_ON;
  logic fire = 1'b0, busy;
  int n_errors = 0, checks_done = 0;
  int cnt = 0, rel = 0, run = 0, req = 0; // model of counter 0
  int cnt1 = 0, rel1 = 0, run1 = 0, tog = 0, chain = 0, cap = 0; // counter 1, output, mode
  logic [31:0] seed = 32'hAE49E667;

  ptimer_top ptimer_top_i (.SYS_CLK(SYS_CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .EVENT_CLOCK_PIN(EVENT_CLOCK_PIN), .EVENT_PORT_IN(EVENT_PORT_IN),
    .TIMER_OUT_SIGNAL(TIMER_OUT_SIGNAL), .FAST_OSCILLATOR_ON(FAST_OSCILLATOR_ON));
  ptimer_event_src ptimer_event_src_i (.clk(SYS_CLK), .rst(RST), .fire(fire),
    .pin(EVENT_CLOCK_PIN), .busy(busy));

  // 100 MHz clock
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= wd;
    SEL_I <= 4'hF;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    rd = DAT_O;
    if (n >= 50) n_errors++;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // mid-run reset, model back to its reset state
  task automatic do_reset;
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    cnt = 0;
    run = 0;
    req = 0;
    cnt1 = 0;
    run1 = 0;
    tog = 0;
    chain = 0;
  endtask

  // one event pulse; model acts on its falling edge
  task automatic pulse;
    int n;
    int uf;
    n = 0;
    uf = 0;
    @(posedge SYS_CLK);
    fire <= 1'b1;
    @(posedge SYS_CLK);
    fire <= 1'b0;
    repeat (9) @(posedge SYS_CLK);
    check(EVENT_PORT_IN, 1'b0);
    while (busy === 1'b1 && n < 60) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (run != 0) begin
      if (cnt == 0) begin
        cnt = rel;
        uf = 1;
      end else begin
        cnt = cnt - 1;
      end
    end
    run = req;
    // chained: counter 1 is clocked by counter 0 underflow
    if (uf != 0 && chain != 0) begin
      if (run1 != 0) begin
        if (cnt1 == 0) begin
          cnt1 = rel1;
          tog = 1 - tog;
        end else begin
          cnt1 = cnt1 - 1;
        end
      end
      run1 = req;
    end else if (uf != 0) begin
      tog = 1 - tog;
    end
  endtask

  // read low then high nibble of counter 0, compare with the model
  task automatic read_cnt0;
    wb(1'b0, OFS_CNT0_LOW, 32'h0);
    check(rd[3:0], cnt[3:0]);
    wb(1'b0, OFS_CNT0_HIGH, 32'h0);
    check(rd[3:0], cnt[7:4]);
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    results();
  end

  // main sequence
  initial begin
    seed = lfsr(seed);
    // reload never below 0x10, output stays slow
    rel = {seed[7:4] | 4'h1, 4'h0};
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    check(FAST_OSCILLATOR_ON, 1'b0);
    wb(1'b0, OFS_OSC, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0);
    check(rd, RST_CTRL);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(EVENT_PORT_IN, 1'b1);
    wb(1'b1, OFS_OSC, 32'h1);
    @(posedge SYS_CLK);
    check(FAST_OSCILLATOR_ON, 1'b1);
    wb(1'b1, OFS_RELOAD0, rel);
    wb(1'b1, OFS_CTRL, 32'h11);
    req = 1;
    wb(1'b0, OFS_CTRL, 32'h0);
    check(rd[0], 1'b1);
    repeat (20) @(posedge SYS_CLK);
    read_cnt0();
    pulse();
    pulse();
    // capture at a count whose high nibble moves on the next decrement
    wb(1'b0, OFS_CNT0_LOW, 32'h0);
    check(rd[3:0], cnt[3:0]);
    cap = cnt;
    pulse();
    wb(1'b0, OFS_CNT0_HIGH, 32'h0);
    check(rd[3:0], cap[7:4]);
    read_cnt0();
    wb(1'b1, OFS_CTRL, 32'h10);
    req = 0;
    wb(1'b0, OFS_CTRL, 32'h0);
    check(rd[0], 1'b1);
    pulse();
    wb(1'b0, OFS_CTRL, 32'h0);
    check(rd[0], 1'b0);
    read_cnt0();
    pulse();
    read_cnt0();
    check(TIMER_OUT_SIGNAL, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h14);
    @(posedge SYS_CLK);
    check(TIMER_OUT_SIGNAL, tog);
    // fast source: no clock until the oscillator runs
    do_reset();
    check(FAST_OSCILLATOR_ON, 1'b0);
    rel = 1;
    wb(1'b1, OFS_RELOAD0, rel);
    wb(1'b1, OFS_CTRL, 32'h21);
    repeat (2 * (int'(DIV_FAST) + 1) + 20) @(posedge SYS_CLK);
    wb(1'b0, OFS_CNT0_LOW, 32'h0);
    check(rd[3:0], 4'h0);
    wb(1'b1, OFS_OSC, 32'h1);
    // two divider ticks: run starts, then reload from zero
    repeat (2 * (int'(DIV_FAST) + 1) + 20) @(posedge SYS_CLK);
    wb(1'b0, OFS_CNT0_LOW, 32'h0);
    check(rd[3:0], 4'(rel));
    // chained 16-bit mode from event pin, four-nibble read order
    do_reset();
    seed = lfsr(seed);
    rel1 = {seed[7:4] | 4'h1, 4'h0};
    rel = 1;
    chain = 1;
    wb(1'b1, OFS_RELOAD0, rel);
    wb(1'b1, OFS_RELOAD1, rel1);
    wb(1'b1, OFS_CTRL, 32'h19);
    req = 1;
    repeat (4) pulse();
    wb(1'b0, OFS_CNT0_LOW, 32'h0);
    check(rd[3:0], cnt[3:0]);
    cap = cnt1;
    wb(1'b0, OFS_CNT0_HIGH, 32'h0);
    check(rd[3:0], cnt[7:4]);
    pulse();
    pulse();
    wb(1'b0, OFS_CNT1_LOW, 32'h0);
    check(rd[3:0], cnt1[3:0]);
    wb(1'b0, OFS_CNT1_HIGH, 32'h0);
    check(rd[3:0], cap[7:4]);
    wb(1'b1, OFS_CTRL, 32'h1D);
    @(posedge SYS_CLK);
    check(TIMER_OUT_SIGNAL, tog);
    results();
  end
endmodule // programmable_down_timer_test
`default_nettype wire
